// ===== rtl/apdm_pkg.sv
package apdm_pkg;
  // First power-mode control byte: field positions
  localparam int PMA_APD_EN_BIT = 1;
  localparam int PMA_TURBO_OFF_BIT = 3;
  localparam int PMA_ARRAY_CLK_OFF_BIT = 4;
  localparam int PMA_MCELL_CLK_OFF_BIT = 5;
  localparam logic [7:0] PMA_WRITE_MASK = 8'h3a;
  // Second power-mode control byte: field positions
  localparam int PMB_WR_OFF_BIT = 2;
  localparam int PMB_RD_OFF_BIT = 3;
  localparam int PMB_PSEN_OFF_BIT = 4;
  localparam int PMB_ALE_OFF_BIT = 5;
  localparam logic [7:0] PMB_WRITE_MASK = 8'h3c;
  localparam logic [7:0] PM_RESET_VALUE = 8'h00;
  // Inactivity limit of the four-bit counter
  localparam logic [3:0] IDLE_LIMIT = 4'hf;
  // Turbo-off standby settle time
  localparam int CLK_PERIOD_NS = 20;
  localparam int TURBO_SETTLE_NS = 70;
  localparam int TURBO_SETTLE_CYCLES =
    (TURBO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_COUNT = 3'(TURBO_SETTLE_CYCLES);
  // Port pin functions, two bits per pin
  localparam logic [1:0] FUNC_MCU_IO = 2'h0;
  localparam logic [1:0] FUNC_PLD_OUT = 2'h1;
  localparam logic [1:0] FUNC_ADDR_OUT = 2'h2;
  localparam logic [1:0] FUNC_PERIPH = 2'h3;
  typedef enum logic [1:0] {
    APDM_ST_RUN = 2'b01,
    APDM_ST_DOWN = 2'b10
  } apdm_state_e;
endpackage

// ===== rtl/apdm_idle_counter.sv
`timescale 1ns/1ps
module apdm_idle_counter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic unit_enable,
  input wire logic address_strobe,
  input wire logic pld_input_clock,
  input wire logic chip_select_in_n,
  input wire logic device_reset,
  output logic power_down_flag,
  output logic [3:0] idle_count
);
  logic strobe_prev;
  logic clock_prev;
  logic strobe_edge;
  logic clock_tick;
  logic exit_cond;
  apdm_pkg::apdm_state_e state;

  assign strobe_edge = address_strobe != strobe_prev;
  // Raw pin clock, never the gated PLD copy
  assign clock_tick = pld_input_clock & ~clock_prev;
  assign exit_cond = strobe_edge | ~chip_select_in_n | device_reset;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      strobe_prev <= 1'b0;
      clock_prev <= 1'b0;
    end else begin
      strobe_prev <= address_strobe;
      clock_prev <= pld_input_clock;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_count <= 4'h0;
    end else if (!unit_enable || strobe_edge || exit_cond) begin
      idle_count <= 4'h0;
    end else if (clock_tick && idle_count != apdm_pkg::IDLE_LIMIT) begin
      idle_count <= idle_count + 4'h1;
    end
  end

  // Entry needs the unit enabled, no exit condition and the fifteenth idle clock tick
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= apdm_pkg::APDM_ST_RUN;
      power_down_flag <= 1'b0;
    end else begin
      unique case (state)
        apdm_pkg::APDM_ST_RUN: begin
          if (unit_enable && !exit_cond && clock_tick &&
              idle_count == apdm_pkg::IDLE_LIMIT - 4'h1) begin
            state <= apdm_pkg::APDM_ST_DOWN;
            power_down_flag <= 1'b1;
          end
        end
        apdm_pkg::APDM_ST_DOWN: begin
          if (exit_cond || !unit_enable) begin
            state <= apdm_pkg::APDM_ST_RUN;
            power_down_flag <= 1'b0;
          end
        end
        default: begin
          state <= apdm_pkg::APDM_ST_RUN;
          power_down_flag <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== rtl/apdm_power_manager.sv
`timescale 1ns/1ps
// Behaviour
// - Two external selects, one term, polarity
// - Select pin driven by term or direction
// - Memories wake only on input change
// - Fifteen idle clock periods raise power-down
// - Unit enable alone permits power-down
// - Strobe, select low, reset exit power-down
// - Power-down blocks bus, deselects memories
// - Idle counter keeps the raw clock
// - Pins keep, undefine or float by function
// - Blocking bits stop signals to logic arrays
// - Bit 3 turbo; off gives 70ns standby
// - Select low enables memories and I/O
// - Select high never blocks logic signals
// - MCU writes both control bytes any time
// - Counter idle when disabled or strobe pulsing
// - Bit 1 enables the power-down unit
// - Bits 4, 5 cut array, cell clock
// - Control bytes cleared only at power-up
module apdm_power_manager #(
  parameter int ADDR_WIDTH = 16,
  parameter int NUM_PINS = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic device_reset,
  input wire logic pm_a_write,
  input wire logic pm_b_write,
  input wire logic [7:0] pm_write_data,
  output logic [7:0] power_mode_control_a,
  output logic [7:0] power_mode_control_b,
  input wire logic address_strobe,
  input wire logic pld_input_clock,
  input wire logic chip_select_in_n,
  input wire logic mcu_wr_n,
  input wire logic mcu_rd_n,
  input wire logic mcu_psen_n,
  input wire logic [ADDR_WIDTH-1:0] mcu_addr,
  input wire logic [7:0] mcu_data,
  input wire logic [1:0] ecs_term,
  input wire logic [1:0] ecs_oe_term,
  input wire logic [1:0] ecs_active_low,
  input wire logic [1:0] port_d_dir,
  input wire logic [2*NUM_PINS-1:0] pin_func,
  input wire logic [NUM_PINS-1:0] pin_out_req,
  input wire logic [NUM_PINS-1:0] pin_oe_req,
  output logic power_down_flag,
  output logic [ADDR_WIDTH-1:0] mem_addr,
  output logic [7:0] mem_data,
  output logic flash_select,
  output logic sram_select,
  output logic io_select,
  output logic mem_active,
  output logic pld_array_clock,
  output logic pld_mcell_clock,
  output logic pld_wr_n,
  output logic pld_rd_n,
  output logic pld_psen_n,
  output logic pld_strobe,
  output logic pld_turbo_on,
  output logic pld_standby,
  output logic [3:0] idle_count,
  output logic [1:0] external_select_outputs,
  output logic [1:0] external_select_oe_n,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n
);
  if (ADDR_WIDTH < 1 || ADDR_WIDTH > 32 || NUM_PINS < 1) begin
    $error("apdm_power_manager: unsupported parameters");
  end

  logic [3:0] next_idle_count;
  logic next_flag;
  logic unit_enable;
  logic [4:0] next_pld_in;
  logic [2:0] settle_count;

  // Control bytes; resetn is the power-up clear only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_mode_control_a <= apdm_pkg::PM_RESET_VALUE;
      power_mode_control_b <= apdm_pkg::PM_RESET_VALUE;
    end else begin
      if (pm_a_write) begin
        power_mode_control_a <=
          pm_write_data & apdm_pkg::PMA_WRITE_MASK;
      end
      if (pm_b_write) begin
        power_mode_control_b <=
          pm_write_data & apdm_pkg::PMB_WRITE_MASK;
      end
    end
  end

  assign unit_enable =
    power_mode_control_a[apdm_pkg::PMA_APD_EN_BIT];

  apdm_idle_counter u_idle (
    .clk(clk),
    .resetn(resetn),
    .unit_enable(unit_enable),
    .address_strobe(address_strobe),
    .pld_input_clock(pld_input_clock),
    .chip_select_in_n(chip_select_in_n),
    .device_reset(device_reset),
    .power_down_flag(next_flag),
    .idle_count(next_idle_count)
  );
  assign power_down_flag = next_flag;
  assign idle_count = next_idle_count;

  // Bus to memories; held frozen in power-down so they stay quiet
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_addr <= '0;
      mem_data <= 8'h00;
      mem_active <= 1'b0;
    end else if (!power_down_flag) begin
      mem_addr <= mcu_addr;
      mem_data <= mcu_data;
      mem_active <= (mcu_addr != mem_addr) || (mcu_data != mem_data);
    end else begin
      mem_active <= 1'b0;
    end
  end

  // Small access-time cost on first select after a high select input
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flash_select <= 1'b0;
      sram_select <= 1'b0;
      io_select <= 1'b0;
    end else begin
      flash_select <= !chip_select_in_n && !power_down_flag;
      sram_select <= !chip_select_in_n && !power_down_flag;
      io_select <= !chip_select_in_n && !power_down_flag;
    end
  end

  // Logic array inputs: blocked ones hold, select input plays no part
  assign next_pld_in = {
    power_mode_control_b[apdm_pkg::PMB_WR_OFF_BIT] ? pld_wr_n : mcu_wr_n,
    power_mode_control_b[apdm_pkg::PMB_RD_OFF_BIT] ? pld_rd_n : mcu_rd_n,
    power_mode_control_b[apdm_pkg::PMB_PSEN_OFF_BIT] ? pld_psen_n
                                                     : mcu_psen_n,
    power_mode_control_b[apdm_pkg::PMB_ALE_OFF_BIT] ? pld_strobe
                                                    : address_strobe,
    power_mode_control_a[apdm_pkg::PMA_ARRAY_CLK_OFF_BIT] ? pld_array_clock
                                                          : pld_input_clock
  };

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pld_wr_n <= 1'b1;
      pld_rd_n <= 1'b1;
      pld_psen_n <= 1'b1;
      pld_strobe <= 1'b0;
      pld_array_clock <= 1'b0;
      pld_mcell_clock <= 1'b0;
    end else begin
      {pld_wr_n, pld_rd_n, pld_psen_n, pld_strobe, pld_array_clock} <=
        next_pld_in;
      if (!power_mode_control_a[apdm_pkg::PMA_MCELL_CLK_OFF_BIT]) begin
        pld_mcell_clock <= pld_input_clock;
      end
    end
  end

  // Turbo off: standby once array inputs settle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      settle_count <= 3'h0;
      pld_standby <= 1'b0;
      pld_turbo_on <= 1'b1;
    end else begin
      pld_turbo_on <=
        !power_mode_control_a[apdm_pkg::PMA_TURBO_OFF_BIT];
      if (next_pld_in != {pld_wr_n, pld_rd_n, pld_psen_n, pld_strobe,
                          pld_array_clock}) begin
        settle_count <= 3'h0;
        pld_standby <= 1'b0;
      end else begin
        if (settle_count != apdm_pkg::SETTLE_COUNT) begin
          settle_count <= settle_count + 3'h1;
        end
        pld_standby <= power_mode_control_a[apdm_pkg::PMA_TURBO_OFF_BIT] &&
          settle_count + 3'h1 >= apdm_pkg::SETTLE_COUNT;
      end
    end
  end

  // External selects on port D pins one and two
  always_ff @(posedge clk) begin
    if (!resetn) begin
      external_select_outputs <= 2'h0;
      external_select_oe_n <= 2'h3;
    end else begin
      external_select_outputs <= ecs_term ^ ecs_active_low;
      external_select_oe_n <= ~(ecs_oe_term | port_d_dir);
    end
  end

  // Pin behaviour during power-down; port logic stays awake
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (!power_down_flag) begin
          pin_out[i] <= pin_out_req[i];
          pin_oe_n[i] <= !pin_oe_req[i];
        end else begin
          unique case (pin_func[2*i +: 2])
            apdm_pkg::FUNC_MCU_IO, apdm_pkg::FUNC_PLD_OUT: begin
              pin_out[i] <= pin_out_req[i];
              pin_oe_n[i] <= !pin_oe_req[i];
            end
            apdm_pkg::FUNC_ADDR_OUT: begin
              pin_out[i] <= 1'b0;
              pin_oe_n[i] <= !pin_oe_req[i];
            end
            apdm_pkg::FUNC_PERIPH: begin
              pin_out[i] <= 1'b0;
              pin_oe_n[i] <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // Checks
  logic [3:0] ticks_idle;
  logic clk_prev_a;
  logic ale_prev_a;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_prev_a <= 1'b0;
      ale_prev_a <= 1'b0;
    end else begin
      clk_prev_a <= pld_input_clock;
      ale_prev_a <= address_strobe;
    end
  end

  property p_entry;
    @(posedge clk) disable iff (!resetn)
      $rose(power_down_flag) |-> $past(unit_enable) &&
      $past(idle_count) == 4'he;
  endproperty
  entry_needs_idle_a: assert property (p_entry)
    else $error("power-down entered before fifteen idle periods");

  strobe_exit_a: assert property (@(posedge clk) disable iff (!resetn)
    power_down_flag && address_strobe != ale_prev_a
    |=> !power_down_flag && idle_count == 4'h0)
    else $error("strobe edge did not end power-down");

  select_exit_a: assert property (@(posedge clk) disable iff (!resetn)
    !chip_select_in_n || device_reset |=> !power_down_flag)
    else $error("exit condition left power-down flag set");

  strobe_clears_a: assert property (@(posedge clk) disable iff (!resetn)
    address_strobe != ale_prev_a |=> idle_count == 4'h0)
    else $error("strobe edge did not clear counter");

  disabled_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !unit_enable |=> idle_count == 4'h0 && !power_down_flag)
    else $error("counter ran with unit disabled");

  bus_frozen_a: assert property (@(posedge clk) disable iff (!resetn)
    power_down_flag ##1 power_down_flag |-> $stable(mem_addr) &&
    $stable(mem_data) && !flash_select && !sram_select)
    else $error("bus reached memories in power-down");

  select_high_a: assert property (@(posedge clk) disable iff (!resetn)
    chip_select_in_n |=> !flash_select && !sram_select)
    else $error("memory selected with select input high");

  array_clk_cut_a: assert property (@(posedge clk) disable iff (!resetn)
    power_mode_control_a[apdm_pkg::PMA_ARRAY_CLK_OFF_BIT]
    |=> $stable(pld_array_clock))
    else $error("blocked clock reached logic array");

  ecs_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    ##1 external_select_oe_n ==
    ~($past(ecs_oe_term) | $past(port_d_dir)))
    else $error("select pin enable wrong");

  periph_float_a: assert property (@(posedge clk) disable iff (!resetn)
    power_down_flag && pin_func[1:0] == apdm_pkg::FUNC_PERIPH
    |=> pin_oe_n[0])
    else $error("peripheral pin driven in power-down");

  turbo_standby_a: assert property (@(posedge clk) disable iff (!resetn)
    pld_standby |-> !pld_turbo_on && $stable({pld_wr_n, pld_rd_n,
    pld_psen_n, pld_strobe, pld_array_clock}))
    else $error("standby reported with turbo on or inputs moving");

  cover_entry_c: cover property (@(posedge clk) disable iff (!resetn)
    $rose(power_down_flag));
  cover_strobe_exit_c: cover property (@(posedge clk) disable iff (!resetn)
    power_down_flag ##1 !power_down_flag && address_strobe != ale_prev_a);
  cover_standby_c: cover property (@(posedge clk) disable iff (!resetn)
    $rose(pld_standby));
endmodule

// ===== tb/apdm_mcu_model.sv
`timescale 1ns/1ps
module apdm_mcu_model (
  input wire logic clk,
  input wire logic run,
  input wire logic noise,
  output logic address_strobe,
  output logic [15:0] mcu_addr,
  output logic [7:0] mcu_data,
  output logic mcu_wr_n,
  output logic mcu_rd_n,
  output logic mcu_psen_n
);
  initial begin
    address_strobe = 1'b0;
    mcu_addr = 16'h0000;
    mcu_data = 8'h00;
    mcu_wr_n = 1'b1;
    mcu_rd_n = 1'b1;
    mcu_psen_n = 1'b1;
  end
  // Sleeping core: strobe and controls hold their level
  always @(posedge clk) begin
    if (run) begin
      address_strobe <= ~address_strobe;
      mcu_wr_n <= ~mcu_wr_n;
      mcu_rd_n <= ~mcu_rd_n;
      mcu_psen_n <= ~mcu_psen_n;
    end
    // Other bus masters may churn the bus with no strobe
    if (run || noise) begin
      mcu_addr <= mcu_addr + 16'h0101;
      mcu_data <= ~mcu_data;
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic device_reset = 1'b0;
  logic pm_a_write = 1'b0;
  logic pm_b_write = 1'b0;
  logic [7:0] pm_write_data = 8'h00;
  logic pld_input_clock = 1'b0;
  logic csi_n = 1'b1;
  logic [1:0] ecs_term = 2'h0, ecs_oe_term = 2'h0;
  logic [1:0] ecs_active_low = 2'h0, port_d_dir = 2'h0;
  logic [15:0] pin_func = 16'h004b;
  logic [7:0] pin_out_req = 8'hff, pin_oe_req = 8'hff;
  logic run = 1'b0, noise = 1'b0, pclk_run = 1'b0;
  logic strobe, wr_n, rd_n, psen_n;
  logic [15:0] addr, mem_addr, m;
  logic [7:0] data, mem_data, ctrl_a, ctrl_b, pin_out, pin_oe_n;
  logic power_down_flag, flash_sel, sram_sel, io_sel, mem_active;
  logic arr_clk, mc_clk, pwr_n, prd_n, ppsen_n, pstrobe;
  logic turbo_on, standby;
  logic [3:0] idle_count;
  logic [1:0] ecs_out, ecs_oe_n;
  logic [5:0] v;
  logic [7:0] md;
  int err_count = 0;
  int checks = 0;

  always #10 clk = ~clk;
  // Pin clock runs at half the core rate, one period per two cycles
  always @(posedge clk) begin
    if (pclk_run) begin
      pld_input_clock <= ~pld_input_clock;
    end
  end

  apdm_mcu_model i_mcu (.clk(clk), .run(run), .noise(noise),
    .address_strobe(strobe), .mcu_addr(addr), .mcu_data(data),
    .mcu_wr_n(wr_n), .mcu_rd_n(rd_n), .mcu_psen_n(psen_n));

  apdm_power_manager #(.ADDR_WIDTH(16), .NUM_PINS(8)) i_dut (
    .clk(clk), .resetn(resetn), .device_reset(device_reset),
    .pm_a_write(pm_a_write), .pm_b_write(pm_b_write),
    .pm_write_data(pm_write_data), .power_mode_control_a(ctrl_a),
    .power_mode_control_b(ctrl_b), .address_strobe(strobe),
    .pld_input_clock(pld_input_clock), .chip_select_in_n(csi_n),
    .mcu_wr_n(wr_n), .mcu_rd_n(rd_n), .mcu_psen_n(psen_n),
    .mcu_addr(addr), .mcu_data(data), .ecs_term(ecs_term),
    .ecs_oe_term(ecs_oe_term), .ecs_active_low(ecs_active_low),
    .port_d_dir(port_d_dir), .pin_func(pin_func),
    .pin_out_req(pin_out_req), .pin_oe_req(pin_oe_req),
    .power_down_flag(power_down_flag), .mem_addr(mem_addr),
    .mem_data(mem_data), .flash_select(flash_sel),
    .sram_select(sram_sel), .io_select(io_sel),
    .mem_active(mem_active), .pld_array_clock(arr_clk),
    .pld_mcell_clock(mc_clk), .pld_wr_n(pwr_n), .pld_rd_n(prd_n),
    .pld_psen_n(ppsen_n), .pld_strobe(pstrobe),
    .pld_turbo_on(turbo_on), .pld_standby(standby),
    .idle_count(idle_count), .external_select_outputs(ecs_out),
    .external_select_oe_n(ecs_oe_n), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));

  task automatic cmp(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic b, input logic [7:0] d);
    @(posedge clk);
    pm_a_write <= !b;
    pm_b_write <= b;
    pm_write_data <= d;
    @(posedge clk);
    pm_a_write <= 1'b0;
    pm_b_write <= 1'b0;
    #1;
  endtask

  task automatic wait_flag(input logic f, input int lim);
    int k;
    k = 0;
    while (power_down_flag !== f && k < lim) begin
      cyc(1);
      k++;
    end
    cmp("power_down_flag", 16'(f), 16'(power_down_flag));
  endtask

  task automatic tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    // Whole sequence needs about 1000 cycles
    #80000;
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    cyc(1);
    cmp("ctrl_a", 16'h0000, 16'(ctrl_a));
    cmp("turbo_on", 16'h0001, 16'(turbo_on));
    wr(1'b0, 8'hff);
    cmp("ctrl_a", 16'h003a, 16'(ctrl_a));
    wr(1'b1, 8'hff);
    cmp("ctrl_b", 16'h003c, 16'(ctrl_b));
    cmp("turbo_on", 16'h0000, 16'(turbo_on));
    v = {arr_clk, mc_clk, pwr_n, prd_n, ppsen_n, pstrobe};
    @(posedge clk);
    pclk_run <= 1'b1;
    run <= 1'b1;
    cyc(12);
    cmp("blocked", 16'(v), 16'({arr_clk, mc_clk, pwr_n, prd_n,
        ppsen_n, pstrobe}));
    cmp("idle_count", 16'h0000, 16'(idle_count));
    @(posedge clk);
    run <= 1'b0;
    cyc(20);
    cmp("early_flag", 16'h0000, 16'(power_down_flag));
    wait_flag(1'b1, 40);
    cmp("idle_count", 16'h000f, 16'(idle_count));
    m = mem_addr;
    md = mem_data;
    @(posedge clk);
    noise <= 1'b1;
    cyc(4);
    cmp("mem_addr", m, mem_addr);
    cmp("mem_data", 16'(md), 16'(mem_data));
    cmp("pin_out", 16'h000c, 16'(pin_out[3:0]));
    cmp("pin_oe_n", 16'h0001, 16'(pin_oe_n[3:0]));
    @(posedge clk);
    noise <= 1'b0;
    for (int e = 0; e < 3; e++) begin
      @(posedge clk);
      case (e)
        0: run <= 1'b1;
        1: csi_n <= 1'b0;
        default: device_reset <= 1'b1;
      endcase
      @(posedge clk);
      run <= 1'b0;
      #1;
      wait_flag(1'b0, 4);
      cmp("idle_count", 16'h0000, 16'(idle_count));
      @(posedge clk);
      csi_n <= 1'b1;
      device_reset <= 1'b0;
      wait_flag(1'b1, 40);
      cmp("ctrl_a", 16'h003a, 16'(ctrl_a));
    end
    wr(1'b0, 8'h00);
    wait_flag(1'b0, 4);
    cyc(40);
    cmp("idle_count", 16'h0000, 16'(idle_count));
    cmp("power_down_flag", 16'h0000, 16'(power_down_flag));
    wr(1'b1, 8'h00);
    @(posedge clk);
    run <= 1'b1;
    cyc(3);
    // Registered copy lags the toggling pin by one cycle
    cmp("pld_wr_n", 16'(!wr_n), 16'(pwr_n));
    cmp("pld_strobe", 16'(!strobe), 16'(pstrobe));
    cmp("selects", 16'h0000, 16'({flash_sel, sram_sel}));
    @(posedge clk);
    csi_n <= 1'b0;
    cyc(3);
    cmp("selects", 16'h0007, 16'({flash_sel, sram_sel, io_sel}));
    cmp("mem_active", 16'h0001, 16'(mem_active));
    @(posedge clk);
    run <= 1'b0;
    pclk_run <= 1'b0;
    cyc(4);
    cmp("mem_active", 16'h0000, 16'(mem_active));
    @(posedge clk);
    csi_n <= 1'b1;
    // Turbo off: quiet inputs let the arrays idle
    wr(1'b0, 8'h08);
    cyc(8);
    cmp("standby", 16'h0001, 16'(standby));
    @(posedge clk);
    run <= 1'b1;
    cyc(4);
    cmp("standby", 16'h0000, 16'(standby));
    @(posedge clk);
    run <= 1'b0;
    wr(1'b0, 8'h00);
    cyc(8);
    cmp("standby", 16'h0000, 16'(standby));
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      {port_d_dir, ecs_oe_term, ecs_active_low, ecs_term} <= i[7:0];
      cyc(2);
      cmp("ecs_out", 16'(2'(i[1:0] ^ i[3:2])), 16'(ecs_out));
      cmp("ecs_oe_n", 16'(2'(~(i[5:4] | i[7:6]))), 16'(ecs_oe_n));
    end
    tally_and_finish;
  end
endmodule
